/* File: interrupt_trap_priority_control.sv */
// Interrupt and trap priority controller with APB register access
`timescale 1ns/1ps
`default_nettype none
module interrupt_trap_priority_control
    import int_trap_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt sources
    input wire logic [NUM_SRC-1:0] irqIn,
    input wire logic [NUM_EXT-1:0] extPin,
    input wire logic [7:0] trapIn,
    input wire logic div0In,
    // CPU side
    output irq_out_t irqOut,
    input wire logic irqAck,
    output logic [3:0] cpuLevel
);
    //==============================================================
    // State
    logic [15:0] ctrlAReg;
    logic [15:0] ctrlBReg;
    logic [FLAG_BITS-1:0] flagReg;
    logic [FLAG_BITS-1:0] enReg;
    logic [2:0] prioReg [NUM_SRC];
    logic [2:0] prioNext [NUM_SRC];
    pending_t pendingReg;
    logic [2:0] cplLowReg;
    logic cplTopReg;
    logic psvReg;
    logic [NUM_EXT-1:0] extSync1Reg;
    logic [NUM_EXT-1:0] extSync2Reg;
    logic [NUM_EXT-1:0] extPrevReg;
    logic [6:0] irqIdxReg;

    //==============================================================
    // APB decode
    logic accessPhase;
    logic doXfer;
    logic doWrite;
    logic [6:0] wordIdx;
    logic inRange;
    logic [6:0] flagOff;
    logic [6:0] enOff;
    logic [6:0] prioOff;
    logic isFlag;
    logic isEn;
    logic isPrio;
    logic mapped;
    logic wrCtrlA;
    logic wrCtrlB;
    logic wrFlag;
    logic wrEn;
    logic wrPrio;
    logic wrStatus;
    logic wrCore;

    assign accessPhase = psel & penable;
    assign doXfer = accessPhase & pready;
    assign doWrite = doXfer & pwrite;
    assign wordIdx = paddr[8:2];
    assign inRange = (paddr[11:9] == 3'h0) && (paddr[1:0] == 2'h0);
    assign flagOff = wordIdx - IDX_FLAG0;
    assign enOff = wordIdx - IDX_EN0;
    assign prioOff = wordIdx - IDX_PRIO0;
    assign isFlag = inRange && wordIdx >= IDX_FLAG0 && wordIdx < IDX_EN0;
    assign isEn = inRange && wordIdx >= IDX_EN0 && wordIdx < IDX_PRIO0;
    assign isPrio = inRange && wordIdx >= IDX_PRIO0 && wordIdx < IDX_PENDING;
    assign mapped = isFlag || isEn || isPrio || (inRange && (wordIdx == IDX_CTRL_A
        || wordIdx == IDX_CTRL_B || wordIdx == IDX_PENDING
        || wordIdx == IDX_STATUS || wordIdx == IDX_CORE));
    assign wrCtrlA = doWrite && inRange && wordIdx == IDX_CTRL_A;
    assign wrCtrlB = doWrite && inRange && wordIdx == IDX_CTRL_B;
    assign wrFlag = doWrite && isFlag;
    assign wrEn = doWrite && isEn;
    assign wrPrio = doWrite && isPrio;
    assign wrStatus = doWrite && inRange && wordIdx == IDX_STATUS;
    assign wrCore = doWrite && inRange && wordIdx == IDX_CORE;

    //==============================================================
    // External pin edge detection
    logic [NUM_EXT-1:0] extEdge;
    logic [FLAG_BITS-1:0] srcEvent;

    // Control B low bits pick the falling edge per pin
    assign extEdge = (ctrlBReg[NUM_EXT-1:0] & extPrevReg & ~extSync2Reg)
        | (~ctrlBReg[NUM_EXT-1:0] & ~extPrevReg & extSync2Reg);

    always_comb
    begin
        srcEvent = '0;
        srcEvent[NUM_SRC-1:0] = irqIn;
        for (int e = 0; e < NUM_EXT; e++)
        begin
            srcEvent[EXT_ORDER[e]] = srcEvent[EXT_ORDER[e]] | extEdge[e];
        end
    end

    //==============================================================
    // Flag, enable and priority next values
    localparam logic [FLAG_BITS-1:0] IMPL_MASK = {{(FLAG_BITS-NUM_SRC){1'b0}}, {NUM_SRC{1'b1}}};
    logic [FLAG_BITS-1:0] flagNext;
    logic [FLAG_BITS-1:0] enNext;
    logic [15:0] ctrlANext;
    logic [7:0] trapSet;

    always_comb
    begin
        flagNext = flagReg;
        if (wrFlag)
        begin
            flagNext[flagOff[2:0]*16 +: 16] = pwdata[15:0];
        end
        // A source event in the clearing cycle still lands
        flagNext = (flagNext | srcEvent) & IMPL_MASK;
    end

    always_comb
    begin
        enNext = enReg;
        if (wrEn)
        begin
            enNext[enOff[2:0]*16 +: 16] = pwdata[15:0];
        end
        enNext = enNext & IMPL_MASK;
    end

    always_comb
    begin
        for (int s = 0; s < NUM_SRC; s++)
        begin
            prioNext[s] = prioReg[s];
        end
        if (wrPrio)
        begin
            for (int k = 0; k < SRC_PER_PRIO; k++)
            begin
                prioNext[prioOff[4:0]*SRC_PER_PRIO+k] = pwdata[4*k +: 3];
            end
        end
    end

    always_comb
    begin
        trapSet = '0;
        trapSet[OSC_BIT] = trapIn[1];
        trapSet[ADDR_BIT] = trapIn[2];
        trapSet[STACK_BIT] = trapIn[3];
        trapSet[MATH_BIT] = trapIn[4] | div0In;
        trapSet[DMA_BIT] = trapIn[5];
        trapSet[DIV0_BIT] = div0In;
        ctrlANext = ctrlAReg;
        if (wrCtrlA)
        begin
            ctrlANext = pwdata[15:0] & CTRL_A_MASK;
        end
        ctrlANext[7:0] = ctrlANext[7:0] | trapSet;
    end

    //==============================================================
    // Arbitration
    logic [3:0] cpl;
    logic [2:0] bestLvl;
    logic [6:0] bestIdx;
    logic userOk;
    logic [2:0] trapSlot;
    logic trapAny;
    logic trapOk;
    logic [3:0] trapLvl;
    logic [6:0] winVec;
    logic [3:0] winLvl;
    logic [23:0] tableBase;
    logic [4:0] trapFlags;

    assign cpl = {cplTopReg, cplLowReg};
    assign trapFlags = {ctrlAReg[DMA_BIT], ctrlAReg[MATH_BIT], ctrlAReg[STACK_BIT],
        ctrlAReg[ADDR_BIT], ctrlAReg[OSC_BIT]};

    always_comb
    begin
        bestLvl = 3'h0;
        bestIdx = 7'h00;
        // Strict compare keeps the lowest natural order on a tie
        for (int i = 0; i < NUM_SRC; i++)
        begin
            if (flagReg[i] && enReg[i] && prioReg[i] > bestLvl)
            begin
                bestLvl = prioReg[i];
                bestIdx = 7'(i);
            end
        end
    end

    always_comb
    begin
        trapSlot = 3'h0;
        trapAny = 1'b0;
        for (int t = 4; t >= 0; t--)
        begin
            if (trapFlags[t])
            begin
                trapSlot = 3'(t + 1);
                trapAny = 1'b1;
            end
        end
    end

    assign userOk = ({1'b0, bestLvl} > cpl) && !cplTopReg && cplLowReg != LVL_BLOCK;
    assign trapLvl = 4'hF - {1'b0, trapSlot};
    assign trapOk = trapAny && trapLvl > cpl;
    assign winVec = trapOk ? {4'h0, trapSlot} : USER_VEC_BASE + bestIdx;
    assign winLvl = trapOk ? trapLvl : {1'b0, bestLvl};
    assign tableBase = ctrlBReg[ALT_TABLE_BIT] ? ALTERNATE_BASE : PRIMARY_BASE;

    //==============================================================
    // Register read mux
    logic [15:0] rdData;

    always_comb
    begin
        rdData = 16'h0000;
        if (isFlag)
        begin
            rdData = flagReg[flagOff[2:0]*16 +: 16];
        end
        else if (isEn)
        begin
            rdData = enReg[enOff[2:0]*16 +: 16];
        end
        else if (isPrio)
        begin
            for (int k = 0; k < SRC_PER_PRIO; k++)
            begin
                rdData[4*k +: 3] = prioReg[prioOff[4:0]*SRC_PER_PRIO+k];
            end
        end
        else if (inRange && wordIdx == IDX_CTRL_A)
        begin
            rdData = ctrlAReg;
        end
        else if (inRange && wordIdx == IDX_CTRL_B)
        begin
            rdData = ctrlBReg;
        end
        else if (inRange && wordIdx == IDX_PENDING)
        begin
            rdData = {4'h0, pendingReg.level, 1'b0, pendingReg.vector};
        end
        else if (inRange && wordIdx == IDX_STATUS)
        begin
            rdData[IPL_LSB +: 3] = cplLowReg;
        end
        else if (inRange && wordIdx == IDX_CORE)
        begin
            rdData[TOP_BIT] = cplTopReg;
            rdData[PSV_BIT] = psvReg;
        end
    end

    //==============================================================
    // CPU priority level next value
    logic [2:0] cplLowNext;
    logic cplTopNext;
    logic takeIrq;

    assign takeIrq = irqAck && irqOut.req;

    always_comb
    begin
        cplLowNext = cplLowReg;
        cplTopNext = cplTopReg;
        if (wrStatus && !ctrlAReg[NEST_BIT])
        begin
            cplLowNext = pwdata[IPL_LSB +: 3];
        end
        if (wrCore && !pwdata[TOP_BIT])
        begin
            cplTopNext = 1'b0;
        end
        if (takeIrq)
        begin
            cplLowNext = irqOut.level[2:0];
            cplTopNext = irqOut.level[3];
            // With nesting off a user interrupt raises the CPU to level 7
            if (ctrlAReg[NEST_BIT] && !irqOut.level[3])
            begin
                cplLowNext = LVL_BLOCK;
            end
        end
    end

    //==============================================================
    // Registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrlAReg <= REG_RESET;
            ctrlBReg <= REG_RESET;
            flagReg <= '0;
            enReg <= '0;
            cplLowReg <= 3'h0;
            cplTopReg <= 1'b0;
            psvReg <= 1'b0;
        end
        else
        begin
            ctrlAReg <= ctrlANext;
            ctrlBReg <= wrCtrlB ? (pwdata[15:0] & CTRL_B_MASK) : ctrlBReg;
            flagReg <= flagNext;
            enReg <= enNext;
            cplLowReg <= cplLowNext;
            cplTopReg <= cplTopNext;
            psvReg <= wrCore ? pwdata[PSV_BIT] : psvReg;
        end
    end

    always_ff @(posedge clk)
    begin
        for (int s = 0; s < NUM_SRC; s++)
        begin
            prioReg[s] <= rst ? 3'h0 : prioNext[s];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            extSync1Reg <= '0;
            extSync2Reg <= '0;
            extPrevReg <= '0;
        end
        else
        begin
            extSync1Reg <= extPin;
            extSync2Reg <= extSync1Reg;
            extPrevReg <= extSync2Reg;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= accessPhase & ~pready;
            prdata <= (accessPhase & ~pready) ? {16'h0000, rdData} : prdata;
            pslverr <= accessPhase & ~pready & ~mapped;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irqOut <= '0;
            irqIdxReg <= 7'h00;
            pendingReg <= '0;
            cpuLevel <= 4'h0;
        end
        else
        begin
            irqOut.req <= trapOk | userOk;
            irqOut.trap <= trapOk;
            irqOut.vector <= winVec;
            irqOut.level <= winLvl;
            irqOut.addr <= tableBase + {16'h0000, winVec, 1'b0};
            irqIdxReg <= bestIdx;
            pendingReg <= takeIrq ? pending_t'{vector: irqOut.vector, level: irqOut.level}
                : pendingReg;
            cpuLevel <= cpl;
        end
    end

    //==============================================================
    // Checks
    // Picks the winner's bit after the mask is shifted down by its index
    localparam logic [FLAG_BITS-1:0] LSB_ONLY = FLAG_BITS'(1);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence apbSetup;
        psel && !penable;
    endsequence
    sequence apbAccess;
        psel && penable && !pready;
    endsequence

    a_apb_one_wait: assert property (apbSetup ##1 apbAccess |=> pready)
        else $error("APB slave did not answer after one wait state");
    a_top_blocks_user: assert property (cplTopReg |=> !(irqOut.req && !irqOut.trap))
        else $error("User interrupt presented with top level bit set");
    a_seven_blocks_user: assert property (cplLowReg == 3'h7 |=> !(irqOut.req && !irqOut.trap))
        else $error("User interrupt presented at level seven");
    a_nest_locks_level: assert property (ctrlAReg[NEST_BIT] && wrStatus && !takeIrq
        |=> cplLowReg == $past(cplLowReg))
        else $error("Level bits changed while nesting disabled");
    a_top_not_settable: assert property (!cplTopReg && !takeIrq |=> !cplTopReg)
        else $error("Top level bit set without an accepted trap");
    a_flag_no_autoclear: assert property (|($past(flagReg) & ~flagReg) |-> $past(wrFlag))
        else $error("Request flag cleared without a software write");
    a_event_sets_flag: assert property (irqIn[0] |=> flagReg[0] ##1 (flagReg[0] || $past(wrFlag)))
        else $error("Source event did not set its flag");
    // The index register and the request come from the state of one cycle earlier
    a_enable_gates_req: assert property (irqOut.req && !irqOut.trap
        |-> |(($past(enReg & flagReg) >> irqIdxReg) & LSB_ONLY))
        else $error("User request presented for a disabled source");
    a_pending_latch: assert property (takeIrq |=> pendingReg.vector == $past(irqOut.vector)
        && pendingReg.level == $past(irqOut.level))
        else $error("Pending register did not latch the taken interrupt");
    a_addr_trap_flag: assert property (trapIn[2] |=> ctrlAReg[ADDR_BIT] [*2])
        else $error("Address trap flag not set and held");
    a_vector_address: assert property (irqOut.req |-> irqOut.addr
        == ($past(ctrlBReg[ALT_TABLE_BIT]) ? ALTERNATE_BASE : PRIMARY_BASE)
        + {16'h0000, irqOut.vector, 1'b0})
        else $error("Vector address does not match the selected table");
    a_level_above_cpu: assert property (irqOut.req |-> irqOut.level > $past(cpl))
        else $error("Presented level does not exceed the CPU level");
endmodule // interrupt_trap_priority_control
`default_nettype wire

/* File: int_trap_pkg.sv */
// Constants, types and register map of the interrupt and trap controller
//==============================================================
//==============================================================
package int_trap_pkg;
    localparam int NUM_SRC = 72;
    localparam int FLAG_WORDS = 5;
    localparam int FLAG_BITS = 80;
    localparam int PRIO_REGS = 18;
    localparam int SRC_PER_PRIO = 4;
    localparam int NUM_EXT = 5;
    // Register word indices; byte address is four times the index
    localparam logic [6:0] IDX_CTRL_A = 7'h00;
    localparam logic [6:0] IDX_CTRL_B = 7'h01;
    localparam logic [6:0] IDX_FLAG0 = 7'h02;
    localparam logic [6:0] IDX_EN0 = 7'h07;
    localparam logic [6:0] IDX_PRIO0 = 7'h0C;
    localparam logic [6:0] IDX_PENDING = 7'h1E;
    localparam logic [6:0] IDX_STATUS = 7'h1F;
    localparam logic [6:0] IDX_CORE = 7'h20;
    // Field positions
    localparam int NEST_BIT = 15;
    localparam int ALT_TABLE_BIT = 15;
    localparam int IPL_LSB = 5;
    localparam int TOP_BIT = 3;
    localparam int PSV_BIT = 2;
    localparam int OSC_BIT = 1;
    localparam int STACK_BIT = 2;
    localparam int ADDR_BIT = 3;
    localparam int MATH_BIT = 4;
    localparam int DMA_BIT = 5;
    localparam int DIV0_BIT = 6;
    localparam logic [15:0] CTRL_A_MASK = 16'h807E;
    localparam logic [15:0] CTRL_B_MASK = 16'h801F;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [2:0] LVL_BLOCK = 3'h7;
    // Vector tables
    localparam logic [23:0] PRIMARY_BASE = 24'h000004;
    localparam logic [23:0] ALTERNATE_BASE = 24'h000104;
    localparam logic [6:0] USER_VEC_BASE = 7'h08;
    // Natural order of the five external request pins
    localparam int EXT_ORDER [NUM_EXT] = '{0, 20, 29, 53, 54};

    typedef struct packed {
        logic req;
        logic trap;
        logic [6:0] vector;
        logic [3:0] level;
        logic [23:0] addr;
    } irq_out_t;

    typedef struct packed {
        logic [6:0] vector;
        logic [3:0] level;
    } pending_t;
endpackage

/* File: cpu_model.sv */
// Behavioural CPU core that accepts the vectors the controller presents
`timescale 1ns/1ps
`default_nettype none
module cpu_model
    import int_trap_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Controller side
    input wire irq_out_t irqOut,
    output logic irqAck,
    // Bench control
    input wire logic ackOn,
    input wire logic [3:0] ackDelay
);
    logic [4:0] waitCnt;
    //==============================================================
    // Acceptance
    // One accept per request episode, so a request that lingers a cycle
    // after the accept is not taken twice
    always_ff @(posedge clk)
    begin
        if (rst || !irqOut.req || !ackOn)
        begin
            waitCnt <= 5'h00;
            irqAck <= 1'b0;
        end
        else
        begin
            irqAck <= (waitCnt == {1'b0, ackDelay});
            if (waitCnt <= {1'b0, ackDelay})
                waitCnt <= waitCnt + 5'h01;
        end
    end
endmodule // cpu_model
`default_nettype wire

/* File: tb_top.sv */
// Self-checking testbench of the interrupt and trap controller
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import int_trap_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NUM_SRC-1:0] irqIn = '0;
    logic [NUM_EXT-1:0] extPin = '0;
    logic [7:0] trapIn = 8'h00;
    logic div0In = 1'b0;
    irq_out_t irqOut;
    logic irqAck;
    logic [3:0] cpuLevel;
    logic ackOn = 1'b0;
    logic [3:0] ackDelay = 4'h0;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;

    always #25 clk = ~clk;

    interrupt_trap_priority_control interrupt_trap_priority_control_i (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irqIn(irqIn), .extPin(extPin), .trapIn(trapIn),
        .div0In(div0In), .irqOut(irqOut), .irqAck(irqAck), .cpuLevel(cpuLevel)
    );

    cpu_model cpu_model_i (
        .clk(clk), .rst(rst), .irqOut(irqOut), .irqAck(irqAck),
        .ackOn(ackOn), .ackDelay(ackDelay)
    );

    //==============================================================
    // Closing report and hang guard
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            complete_run();
        end
    end

    //==============================================================
    // Compare and bus tasks
    // Shared counting and reporting behind the typed compare tasks
    task automatic tally(input logic ok, input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (!ok)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkBus(input logic [32:0] got, input logic [32:0] exp);
        tally(got === exp, 64'(got), 64'(exp));
    endtask

    task automatic chkLvl(input logic [3:0] got, input logic [3:0] exp);
        tally(got === exp, 64'(got), 64'(exp));
    endtask

    task automatic chkIrq(input irq_out_t got, input irq_out_t exp);
        tally(got === exp, 64'(got), 64'(exp));
    endtask

    task automatic chkReq(input logic got, input logic exp);
        tally(got === exp, 64'(got), 64'(exp));
    endtask

    function automatic logic [11:0] ad(input logic [6:0] idx);
        return {3'h0, idx, 2'b00};
    endfunction

    function automatic irq_out_t mk(input logic trap, input logic [6:0] vec,
        input logic [3:0] lvl, input logic [23:0] base);
        return '{req: 1'b1, trap: trap, vector: vec, level: lvl,
            addr: base + {16'h0, vec, 1'b0}};
    endfunction

    // Request held from setup until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [6:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, ad(idx), d, r, e);
    endtask

    task automatic rdChk(input logic [11:0] a, input logic e0, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chkBus({e, r}, {e0, exp});
    endtask

    task automatic waitCyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Request presence and fields are sampled as they stood at the edge
    task automatic chkOut(input logic on, input irq_out_t exp);
        @(posedge clk);
        if (on)
            chkIrq(irqOut, exp);
        else
            chkReq(irqOut.req, 1'b0);
    endtask

    //==============================================================
    // Main sequence
    initial
    begin
        waitCyc(4);
        rst <= 1'b0;
        rdChk(ad(IDX_CTRL_A), 1'b0, 32'h0);
        rdChk(ad(IDX_CORE), 1'b0, 32'h0);
        wr(IDX_PENDING, 32'h0000_0F7F);
        rdChk(ad(IDX_PENDING), 1'b0, 32'h0);
        rdChk(12'h084, 1'b1, 32'h0);
        // Level 7 in the low bits
        wr(IDX_STATUS, 32'h0000_00E0);
        waitCyc(2);
        chkLvl(cpuLevel, 4'h7);
        rdChk(ad(IDX_STATUS), 1'b0, 32'h0000_00E0);
        // Two equal-priority sources, only the second enabled
        wr(IDX_PRIO0, 32'h0000_0033);
        wr(IDX_EN0, 32'h0000_0002);
        @(posedge clk);
        extPin <= 5'h01;
        irqIn <= 72'h2;
        @(posedge clk);
        irqIn <= '0;
        waitCyc(6);
        rdChk(ad(IDX_FLAG0), 1'b0, 32'h0000_0003);
        chkOut(1'b0, '0);
        wr(IDX_STATUS, 32'h0);
        waitCyc(3);
        chkOut(1'b1, mk(1'b0, 7'h09, 4'h3, PRIMARY_BASE));
        wr(IDX_EN0, 32'h0000_0003);
        waitCyc(3);
        chkOut(1'b1, mk(1'b0, 7'h08, 4'h3, PRIMARY_BASE));
        wr(IDX_CTRL_B, 32'h0000_8000);
        waitCyc(3);
        chkOut(1'b1, mk(1'b0, 7'h08, 4'h3, ALTERNATE_BASE));
        // Slow accept by the CPU
        ackDelay <= 4'h3;
        ackOn <= 1'b1;
        waitCyc(10);
        rdChk(ad(IDX_PENDING), 1'b0, 32'h0000_0308);
        chkLvl(cpuLevel, 4'h3);
        chkOut(1'b0, '0);
        rdChk(ad(IDX_FLAG0), 1'b0, 32'h0000_0003);
        ackOn <= 1'b0;
        // Level bits frozen by nesting disable
        wr(IDX_CTRL_A, 32'h0000_8000);
        wr(IDX_STATUS, 32'h0);
        rdChk(ad(IDX_STATUS), 1'b0, 32'h0000_0060);
        wr(IDX_CTRL_A, 32'h0);
        wr(IDX_FLAG0, 32'h0);
        rdChk(ad(IDX_FLAG0), 1'b0, 32'h0);
        wr(IDX_STATUS, 32'h0);
        wr(IDX_CTRL_B, 32'h0);
        // Address trap, then a user source that the top bit must hold off
        @(posedge clk);
        trapIn <= 8'h04;
        @(posedge clk);
        trapIn <= 8'h00;
        waitCyc(4);
        chkOut(1'b1, mk(1'b1, 7'h02, 4'hD, PRIMARY_BASE));
        rdChk(ad(IDX_CTRL_A), 1'b0, 32'h0000_0008);
        wr(IDX_PRIO0, 32'h0000_0006);
        wr(IDX_EN0, 32'h0000_0001);
        @(posedge clk);
        irqIn <= 72'h1;
        @(posedge clk);
        irqIn <= '0;
        ackDelay <= 4'h0;
        ackOn <= 1'b1;
        waitCyc(10);
        chkLvl(cpuLevel, 4'hD);
        rdChk(ad(IDX_CORE), 1'b0, 32'h0000_0008);
        rdChk(ad(IDX_STATUS), 1'b0, 32'h0000_00A0);
        chkOut(1'b0, '0);
        ackOn <= 1'b0;
        wr(IDX_CTRL_A, 32'h0);
        wr(IDX_CORE, 32'h0);
        waitCyc(3);
        chkOut(1'b1, mk(1'b0, 7'h08, 4'h6, PRIMARY_BASE));
        wr(IDX_CORE, 32'h0000_0008);
        rdChk(ad(IDX_CORE), 1'b0, 32'h0);
        // Divide by zero marks both arithmetic status bits
        @(posedge clk);
        div0In <= 1'b1;
        @(posedge clk);
        div0In <= 1'b0;
        waitCyc(3);
        rdChk(ad(IDX_CTRL_A), 1'b0, 32'h0000_0050);
        // Falling-edge sense on pin zero: only the fall may set its flag
        wr(IDX_FLAG0, 32'h0);
        wr(IDX_CTRL_B, 32'h0000_0001);
        @(posedge clk);
        extPin <= 5'h00;
        waitCyc(5);
        rdChk(ad(IDX_FLAG0), 1'b0, 32'h0000_0001);
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
